// file: common/ufc_pkg.sv
// Shared constants and types of the UART flow and trigger configuration block.
package ufc_pkg;

  // ---------------------------------------------------------------------
  // Register byte addresses on the APB slave.
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_ENH_FEATURE  = 8'h00;
  localparam logic [7:0] ADDR_DIV_LOW      = 8'h04;
  localparam logic [7:0] ADDR_DIV_HIGH     = 8'h08;
  localparam logic [7:0] ADDR_FLOW_THRESH  = 8'h0c;
  localparam logic [7:0] ADDR_TRIG_LEVELS  = 8'h10;
  localparam logic [7:0] ADDR_TX_SPACE     = 8'h14;
  localparam logic [7:0] ADDR_RX_FILL      = 8'h18;
  localparam logic [7:0] ADDR_INT_ENABLE   = 8'h1c;
  localparam logic [7:0] ADDR_FIFO_CTRL    = 8'h20;
  localparam logic [7:0] ADDR_MODEM_CTRL   = 8'h24;
  localparam logic [7:0] ADDR_STOP_CHAR2   = 8'h28;
  localparam logic [7:0] ADDR_EVT_STATUS   = 8'h2c;
  localparam logic [7:0] ADDR_EVT_MASK     = 8'h30;
  localparam logic [7:0] ADDR_INT_IDENT    = 8'h34;

  // ---------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------
  localparam int FEA_CTS_EN     = 7;
  localparam int FEA_RTS_EN     = 6;
  localparam int FEA_SPECIAL_EN = 5;
  localparam int FEA_ENH_EN     = 4;
  localparam int IEN_SLEEP      = 4;
  localparam int MDM_THR_ACCESS = 2;
  localparam int MDM_RTS        = 1;
  localparam int IDN_SPECIAL    = 4;
  localparam int IDN_NONE       = 0;
  localparam int FCT_RX_TRIG_LO = 6;
  localparam int FCT_TX_TRIG_LO = 4;
  localparam int NIB_SHIFT      = 2;

  // Bits that only change while enhanced functions are enabled.
  localparam logic [7:0] IEN_PROT_MASK = 8'hf0;
  localparam logic [7:0] FCT_PROT_MASK = 8'h30;
  localparam logic [7:0] MDM_PROT_MASK = 8'he4;

  // Reset value of every control register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Event status bits.
  // ---------------------------------------------------------------------
  localparam int EV_SPECIAL = 0;
  localparam int EV_CTS_HLT = 1;
  localparam int EV_RTS_HLT = 2;
  localparam int EV_RX_TRIG = 3;
  localparam int EV_TX_TRIG = 4;
  localparam int EV_NUM     = 5;

  // Fallback trigger levels selected by the FIFO control fields.
  localparam logic [3:0][6:0] FCT_RX_LVL = {7'h3c, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][6:0] FCT_TX_LVL = {7'h38, 7'h20, 7'h10, 7'h08};

  // One received character from the serial datapath.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ufc_rxchar_t;

endpackage

// file: logic/ufc_sync2.sv
// Two flip-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module ufc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // Sampling clock.
  input  wire logic             rst_b,  // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] d,      // Asynchronous input.
  output logic      [WIDTH-1:0] q       // Synchronised output.
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// file: logic/ufc_top.sv
// UART flow control, divisor and trigger level configuration with APB access.
//
// What this block does
// - CTS high halts transmitter when enabled.
// - RTS high at halt level, low at resume.
// - Special character match flags identification bit.
// - Enhanced enable gates protected control bits.
// - Low feature nibble selects software flow mode.
// - Divisor is high byte and low byte.
// - Divisor writes ignored while sleep enabled.
// - Threshold nibbles mean levels in fours.
// - Threshold register needs enhanced and access bits.
// - Trigger nibbles: receive high, transmit low.
// - Trigger register needs enhanced and access bits.
// - Zero trigger nibble falls back to FIFO control.
// - Transmit space count reads free spaces.
// - Receive fill count reads stored characters.
// - Modem control protected bits need enhanced enable.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module ufc_top (
  input  wire logic               SYS_CLK,        // System clock, 20 MHz.
  input  wire logic               RST_B,          // Synchronous reset.
  input  wire logic               PSEL,           // APB select.
  input  wire logic               PENABLE,        // APB access phase.
  input  wire logic               PWRITE,         // APB write direction.
  input  wire logic [7:0]         PADDR,          // APB byte address.
  input  wire logic [31:0]        PWDATA,         // APB write data.
  output logic      [31:0]        PRDATA,         // APB read data.
  output logic                    PREADY,         // APB ready.
  output logic                    PSLVERR,        // APB error.
  input  wire logic               CTS_PIN,        // Clear to send pin.
  output logic                    RTS_PIN,        // Request to send pin.
  output logic                    TX_HALT,        // Stop transmitter.
  input  wire ufc_pkg::ufc_rxchar_t RX_CHAR,      // Received character.
  input  wire logic [6:0]         TX_FREE,        // Free TX FIFO spaces.
  input  wire logic [6:0]         RX_FILL,        // Characters in RX FIFO.
  output logic      [15:0]        BAUD_DIVISOR,   // Baud generator divisor.
  output logic      [3:0]         SWFLOW_MODE,    // Software flow select.
  output logic                    SLEEP_EN,       // Sleep mode enable.
  output logic      [6:0]         RX_TRIG_LEVEL,  // Active RX trigger.
  output logic      [6:0]         TX_TRIG_LEVEL,  // Active TX trigger.
  output logic                    RX_TRIG_HIT,    // RX trigger reached.
  output logic                    TX_TRIG_HIT,    // TX trigger reached.
  output logic                    IRQ             // Interrupt, active high.
);

  // ---------------------------------------------------------------------
  // Helper functions.
  // ---------------------------------------------------------------------

  // Turns a level nibble into a character count in steps of four.
  function automatic logic [6:0] nib_level(input logic [3:0] nib);
    nib_level = {1'b0, nib, 2'b00};
  endfunction

  // Applies a write, keeping protected bits when the gate is closed.
  function automatic logic [7:0] prot_merge(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic [7:0] mask,
    input logic       open_g
  );
    if (open_g) begin
      prot_merge = new_v;
    end else begin
      prot_merge = (old_v & mask) | (new_v & ~mask);
    end
  endfunction

  // ---------------------------------------------------------------------
  // Registers and internal signals.
  // ---------------------------------------------------------------------
  logic [7:0]          fea_q;
  logic [7:0]          dvl_q;
  logic [7:0]          dvh_q;
  logic [7:0]          thr_q;
  logic [7:0]          trg_q;
  logic [7:0]          ien_q;
  logic [7:0]          fct_q;
  logic [7:0]          mdm_q;
  logic [7:0]          stop2_q;
  logic [ufc_pkg::EV_NUM-1:0] st_q;
  logic [ufc_pkg::EV_NUM-1:0] st_d;
  logic [ufc_pkg::EV_NUM-1:0] mask_q;
  logic [ufc_pkg::EV_NUM-1:0] ev;
  logic [31:0]         prdata_q;
  logic [31:0]         rd_val;
  logic                rd_ok;
  logic                wr;
  logic [7:0]          wdat;
  logic                enh;
  logic                thr_open;
  logic                cts_s;
  logic                cts_d_q;
  logic                rts_q;
  logic                halt_q;
  logic                rx_hit_q;
  logic                tx_hit_q;
  logic [6:0]          halt_lvl;
  logic [6:0]          resume_lvl;
  logic [6:0]          rx_lvl;
  logic [6:0]          tx_lvl;

  // ---------------------------------------------------------------------
  // Pin synchronisation.
  // ---------------------------------------------------------------------

  // The clear to send pin is asynchronous and is synchronised first.
  ufc_sync2 #(
    .WIDTH (1)
  ) u_cts_sync (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .d     (CTS_PIN),
    .q     (cts_s)
  );

  // ---------------------------------------------------------------------
  // APB decode.
  // ---------------------------------------------------------------------

  // Writes take effect in the access cycle, which always completes.
  assign wr       = PSEL & PENABLE & PWRITE;
  assign wdat     = PWDATA[7:0];
  assign enh      = fea_q[ufc_pkg::FEA_ENH_EN];
  assign thr_open = enh & mdm_q[ufc_pkg::MDM_THR_ACCESS];
  assign PREADY   = PSEL & PENABLE;
  assign PSLVERR  = PSEL & PENABLE & ~rd_ok;
  assign PRDATA   = prdata_q;

  // Read mux; unmapped addresses read zero and flag an error.
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (PADDR)
      ufc_pkg::ADDR_ENH_FEATURE: rd_val[7:0] = fea_q;
      ufc_pkg::ADDR_DIV_LOW:     rd_val[7:0] = dvl_q;
      ufc_pkg::ADDR_DIV_HIGH:    rd_val[7:0] = dvh_q;
      ufc_pkg::ADDR_FLOW_THRESH: rd_val[7:0] = thr_q;
      ufc_pkg::ADDR_TRIG_LEVELS: rd_val[7:0] = trg_q;
      ufc_pkg::ADDR_TX_SPACE:    rd_val[6:0] = TX_FREE;
      ufc_pkg::ADDR_RX_FILL:     rd_val[6:0] = RX_FILL;
      ufc_pkg::ADDR_INT_ENABLE:  rd_val[7:0] = ien_q;
      ufc_pkg::ADDR_FIFO_CTRL:   rd_val[7:0] = fct_q;
      ufc_pkg::ADDR_MODEM_CTRL:  rd_val[7:0] = mdm_q;
      ufc_pkg::ADDR_STOP_CHAR2:  rd_val[7:0] = stop2_q;
      ufc_pkg::ADDR_EVT_STATUS:  rd_val[ufc_pkg::EV_NUM-1:0] = st_q;
      ufc_pkg::ADDR_EVT_MASK:    rd_val[ufc_pkg::EV_NUM-1:0] = mask_q;
      ufc_pkg::ADDR_INT_IDENT: begin
        rd_val[ufc_pkg::IDN_SPECIAL] = st_q[ufc_pkg::EV_SPECIAL];
        rd_val[ufc_pkg::IDN_NONE]    = ~IRQ;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      prdata_q <= '0;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      prdata_q <= rd_val;
    end
  end

  // ---------------------------------------------------------------------
  // Feature and modem control registers.
  // ---------------------------------------------------------------------

  // Enhanced feature register; all enables clear at reset.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      fea_q <= ufc_pkg::REG_RESET;
    end else if (wr && PADDR == ufc_pkg::ADDR_ENH_FEATURE) begin
      fea_q <= wdat;
    end
  end

  // Interrupt enable register with its protected upper nibble.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ien_q <= ufc_pkg::REG_RESET;
    end else if (wr && PADDR == ufc_pkg::ADDR_INT_ENABLE) begin
      ien_q <= prot_merge(ien_q, wdat, ufc_pkg::IEN_PROT_MASK, enh);
    end
  end

  // FIFO control register with its protected transmit trigger field.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      fct_q <= ufc_pkg::REG_RESET;
    end else if (wr && PADDR == ufc_pkg::ADDR_FIFO_CTRL) begin
      fct_q <= prot_merge(fct_q, wdat, ufc_pkg::FCT_PROT_MASK, enh);
    end
  end

  // Modem control register; upper bits and the access bit are guarded.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      mdm_q <= ufc_pkg::REG_RESET;
    end else if (wr && PADDR == ufc_pkg::ADDR_MODEM_CTRL) begin
      mdm_q <= prot_merge(mdm_q, wdat, ufc_pkg::MDM_PROT_MASK, enh);
    end
  end

  // Second stop character used for special character detection.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      stop2_q <= ufc_pkg::REG_RESET;
    end else if (wr && PADDR == ufc_pkg::ADDR_STOP_CHAR2) begin
      stop2_q <= wdat;
    end
  end

  // ---------------------------------------------------------------------
  // Divisor, threshold and trigger level registers.
  // ---------------------------------------------------------------------

  // Divisor bytes; writes are dropped once sleep mode is on.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      dvl_q <= ufc_pkg::REG_RESET;
      dvh_q <= ufc_pkg::REG_RESET;
    end else if (wr && !ien_q[ufc_pkg::IEN_SLEEP]) begin
      if (PADDR == ufc_pkg::ADDR_DIV_LOW) begin
        dvl_q <= wdat;
      end
      if (PADDR == ufc_pkg::ADDR_DIV_HIGH) begin
        dvh_q <= wdat;
      end
    end
  end

  // Flow thresholds and trigger levels share the same write gate.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      thr_q <= ufc_pkg::REG_RESET;
      trg_q <= ufc_pkg::REG_RESET;
    end else if (wr && thr_open) begin
      if (PADDR == ufc_pkg::ADDR_FLOW_THRESH) begin
        thr_q <= wdat;
      end
      if (PADDR == ufc_pkg::ADDR_TRIG_LEVELS) begin
        trg_q <= wdat;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Configuration outputs.
  // ---------------------------------------------------------------------

  // Divisor high byte above low byte; low feature nibble picks Xon/Xoff.
  assign BAUD_DIVISOR = {dvh_q, dvl_q};
  assign SWFLOW_MODE  = fea_q[3:0];
  assign SLEEP_EN     = ien_q[ufc_pkg::IEN_SLEEP];

  // Halt level sits in the low nibble, resume in the high nibble.
  assign halt_lvl   = nib_level(thr_q[3:0]);
  assign resume_lvl = nib_level(thr_q[7:4]);

  // A zero trigger nibble falls back to the FIFO control selection.
  always_comb begin
    if (trg_q[7:4] != 4'h0) begin
      rx_lvl = nib_level(trg_q[7:4]);
    end else begin
      rx_lvl = ufc_pkg::FCT_RX_LVL[fct_q[ufc_pkg::FCT_RX_TRIG_LO +: 2]];
    end
    if (trg_q[3:0] != 4'h0) begin
      tx_lvl = nib_level(trg_q[3:0]);
    end else begin
      tx_lvl = ufc_pkg::FCT_TX_LVL[fct_q[ufc_pkg::FCT_TX_TRIG_LO +: 2]];
    end
  end

  assign RX_TRIG_LEVEL = rx_lvl;
  assign TX_TRIG_LEVEL = tx_lvl;

  // Trigger comparisons are registered before use.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rx_hit_q <= 1'b0;
      tx_hit_q <= 1'b0;
    end else begin
      rx_hit_q <= (RX_FILL >= rx_lvl);
      tx_hit_q <= (TX_FREE >= tx_lvl);
    end
  end

  assign RX_TRIG_HIT = rx_hit_q;
  assign TX_TRIG_HIT = tx_hit_q;

  // ---------------------------------------------------------------------
  // Hardware flow control.
  // ---------------------------------------------------------------------

  // Transmitter halts while the synchronised CTS level is high.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      halt_q  <= 1'b0;
      cts_d_q <= 1'b0;
    end else begin
      halt_q  <= fea_q[ufc_pkg::FEA_CTS_EN] & cts_s;
      cts_d_q <= cts_s;
    end
  end

  assign TX_HALT = halt_q;

  // RTS rises at the halt level and falls at the resume level.
  // Without auto flow control the modem control bit drives the pin.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rts_q <= 1'b1;
    end else if (fea_q[ufc_pkg::FEA_RTS_EN]) begin
      if (RX_FILL >= halt_lvl) begin
        rts_q <= 1'b1;
      end else if (RX_FILL <= resume_lvl) begin
        rts_q <= 1'b0;
      end
    end else begin
      rts_q <= ~mdm_q[ufc_pkg::MDM_RTS];
    end
  end

  assign RTS_PIN = rts_q;

  // ---------------------------------------------------------------------
  // Events and interrupt.
  // ---------------------------------------------------------------------

  // Event pulses; the matching character is still stored by the datapath.
  always_comb begin
    ev = '0;
    ev[ufc_pkg::EV_SPECIAL] = RX_CHAR.valid & fea_q[ufc_pkg::FEA_SPECIAL_EN]
                              & (RX_CHAR.data == stop2_q);
    ev[ufc_pkg::EV_CTS_HLT] = fea_q[ufc_pkg::FEA_CTS_EN] & cts_s & ~cts_d_q;
    ev[ufc_pkg::EV_RTS_HLT] = fea_q[ufc_pkg::FEA_RTS_EN] & ~rts_q
                              & (RX_FILL >= halt_lvl);
    ev[ufc_pkg::EV_RX_TRIG] = (RX_FILL >= rx_lvl) & ~rx_hit_q;
    ev[ufc_pkg::EV_TX_TRIG] = (TX_FREE >= tx_lvl) & ~tx_hit_q;
  end

  // Sticky status, write one to clear; a new event beats the clear.
  always_comb begin
    st_d = st_q;
    if (wr && PADDR == ufc_pkg::ADDR_EVT_STATUS) begin
      st_d = st_q & ~PWDATA[ufc_pkg::EV_NUM-1:0];
    end
    st_d = st_d | ev;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Interrupt mask, one bit per event.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      mask_q <= '0;
    end else if (wr && PADDR == ufc_pkg::ADDR_EVT_MASK) begin
      mask_q <= PWDATA[ufc_pkg::EV_NUM-1:0];
    end
  end

  assign IRQ = |(st_q & mask_q);

endmodule

// file: testbench/ufc_checker.sv
// Concurrent checks on the ports of the flow and trigger configuration block.
`timescale 1ns/1ps
module ufc_checker (
  input wire logic        SYS_CLK,        // Clock.
  input wire logic        RST_B,          // Reset, active low.
  input wire logic        PSEL,           // Select.
  input wire logic        PENABLE,        // Access phase.
  input wire logic        PWRITE,         // Direction.
  input wire logic [7:0]  PADDR,          // Address.
  input wire logic [31:0] PWDATA,         // Write data.
  input wire logic [31:0] PRDATA,         // Read data.
  input wire logic        PSLVERR,        // Error.
  input wire logic        CTS_PIN,        // Clear to send.
  input wire logic        TX_HALT,        // Transmitter stop.
  input wire logic [6:0]  TX_FREE,        // Free spaces.
  input wire logic [6:0]  RX_FILL,        // Stored characters.
  input wire logic [15:0] BAUD_DIVISOR,   // Divisor.
  input wire logic        SLEEP_EN,       // Sleep enable.
  input wire logic [6:0]  RX_TRIG_LEVEL,  // Receive trigger.
  input wire logic [6:0]  TX_TRIG_LEVEL,  // Transmit trigger.
  input wire logic        RX_TRIG_HIT,    // Receive trigger hit.
  input wire logic        TX_TRIG_HIT     // Transmit trigger hit.
);
  // ----------------------------------------------------------------
  // Bus phase decode.
  // ----------------------------------------------------------------
  // Write access cycle and read setup cycle of the bus.
  wire wr = PSEL && PENABLE && PWRITE;
  wire rs = PSEL && !PENABLE && !PWRITE;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  chk_div_low_load: assert property (
    wr && PADDR == ufc_pkg::ADDR_DIV_LOW && !SLEEP_EN
    |=> BAUD_DIVISOR[7:0] == $past(PWDATA[7:0]))
    else $error("Divisor low byte not loaded.");
  chk_div_write_gate: assert property ($changed(BAUD_DIVISOR) |->
    $past(wr && !SLEEP_EN && (PADDR == ufc_pkg::ADDR_DIV_LOW
          || PADDR == ufc_pkg::ADDR_DIV_HIGH)))
    else $error("Divisor changed without an open write.");
  chk_tx_space_read: assert property (
    rs && PADDR == ufc_pkg::ADDR_TX_SPACE
    |=> PRDATA == {25'h0, $past(TX_FREE)})
    else $error("Transmit space read wrong.");
  chk_rx_fill_read: assert property (
    rs && PADDR == ufc_pkg::ADDR_RX_FILL
    |=> PRDATA == {25'h0, $past(RX_FILL)})
    else $error("Receive fill read wrong.");
  chk_cts_halt_clear: assert property (
    !CTS_PIN [*3] |=> !TX_HALT) else $error("Halt without clear to send.");
  chk_tx_trig_hit: assert property (
    RST_B |=> TX_TRIG_HIT == ($past(TX_FREE) >= $past(TX_TRIG_LEVEL)))
    else $error("Transmit trigger hit wrong.");
  chk_rx_trig_hit: assert property (
    RST_B |=> RX_TRIG_HIT == ($past(RX_FILL) >= $past(RX_TRIG_LEVEL)))
    else $error("Receive trigger hit wrong.");
  chk_trig_write_gate: assert property ($changed(TX_TRIG_LEVEL) |->
    $past(wr && (PADDR == ufc_pkg::ADDR_TRIG_LEVELS
          || PADDR == ufc_pkg::ADDR_FIFO_CTRL)))
    else $error("Transmit trigger changed without a write.");
  chk_trig_grain: assert property (
    RX_TRIG_LEVEL[1:0] == 2'h0 && RX_TRIG_LEVEL inside {[7'h04:7'h3c]})
    else $error("Receive trigger level off the grid.");
  chk_mapped_no_err: assert property (
    PSEL && PENABLE && PADDR <= ufc_pkg::ADDR_INT_IDENT
    && PADDR[1:0] == 2'h0 |-> !PSLVERR)
    else $error("Error on a mapped register.");

  cov_div_write: cover property (wr && PADDR == ufc_pkg::ADDR_DIV_LOW);
  cov_tx_halt: cover property ($rose(TX_HALT));
  cov_tx_hit: cover property ($rose(TX_TRIG_HIT));
endmodule

bind ufc_top ufc_checker i_chk (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PSLVERR(PSLVERR), .CTS_PIN(CTS_PIN), .TX_HALT(TX_HALT),
  .TX_FREE(TX_FREE), .RX_FILL(RX_FILL), .BAUD_DIVISOR(BAUD_DIVISOR),
  .SLEEP_EN(SLEEP_EN), .RX_TRIG_LEVEL(RX_TRIG_LEVEL),
  .TX_TRIG_LEVEL(TX_TRIG_LEVEL), .RX_TRIG_HIT(RX_TRIG_HIT),
  .TX_TRIG_HIT(TX_TRIG_HIT));

// file: testbench/ufc_remote_model.sv
// Remote serial partner that fills the receive queue until told to halt.
`timescale 1ns/1ps
module ufc_remote_model (
  input  wire logic       clk,    // Clock.
  input  wire logic       rst_b,  // Reset, active low.
  input  wire logic       rts,    // Halt request from the UART.
  input  wire logic       send,   // Remote has characters to send.
  input  wire logic       drain,  // Host takes one character a cycle.
  output logic      [6:0] fill    // Receive queue fill level.
);
  logic [6:0] fill_q;

  // One character arrives a cycle while sending and not halted.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fill_q <= 7'h00;
    end else if (drain && fill_q != 7'h00) begin
      fill_q <= fill_q - 7'h01;
    end else if (send && !rts && fill_q < 7'h40) begin
      fill_q <= fill_q + 7'h01;
    end
  end

  assign fill = fill_q;
endmodule

// file: testbench/uart_flow_trigger_config_tb_top.sv
// Self-checking testbench of the flow and trigger configuration block.
`timescale 1ns/1ps
module uart_flow_trigger_config_tb_top;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic       e;
  } ufc_row_t;

  logic                 sys_clk, pready, pslverr, rts, tx_halt, er;
  logic                 sleep_en, rx_hit, tx_hit, irq;
  logic                 rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                 pwrite = 1'b0, cts = 1'b0, send = 1'b0;
  logic                 drain = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, rd;
  logic [6:0]           tx_free = 7'h40, rx_fill, rx_lvl, tx_lvl;
  logic [15:0]          baud;
  logic [3:0]           swflow;
  ufc_pkg::ufc_rxchar_t rx_char = '0;
  int                   failures = 0, checked = 0, cycles = 0;
  ufc_row_t             rows[16] = '{
    '{ufc_pkg::ADDR_INT_ENABLE,  8'hf1, 8'h01, 1'b0},
    '{ufc_pkg::ADDR_FIFO_CTRL,   8'hf0, 8'hc0, 1'b0},
    '{ufc_pkg::ADDR_MODEM_CTRL,  8'he6, 8'h02, 1'b0},
    '{ufc_pkg::ADDR_FLOW_THRESH, 8'h24, 8'h00, 1'b0},
    '{ufc_pkg::ADDR_TRIG_LEVELS, 8'h32, 8'h00, 1'b0},
    '{ufc_pkg::ADDR_ENH_FEATURE, 8'h1f, 8'h1f, 1'b0},
    '{ufc_pkg::ADDR_FLOW_THRESH, 8'h24, 8'h00, 1'b0},
    '{ufc_pkg::ADDR_MODEM_CTRL,  8'h04, 8'h04, 1'b0},
    '{ufc_pkg::ADDR_FLOW_THRESH, 8'h24, 8'h24, 1'b0},
    '{ufc_pkg::ADDR_TRIG_LEVELS, 8'h32, 8'h32, 1'b0},
    '{ufc_pkg::ADDR_FIFO_CTRL,   8'h30, 8'h30, 1'b0},
    '{ufc_pkg::ADDR_DIV_LOW,     8'h34, 8'h34, 1'b0},
    '{ufc_pkg::ADDR_DIV_HIGH,    8'h12, 8'h12, 1'b0},
    '{ufc_pkg::ADDR_TX_SPACE,    8'h00, 8'h40, 1'b0},
    '{ufc_pkg::ADDR_RX_FILL,     8'h55, 8'h00, 1'b0},
    '{8'h3c,                     8'h5a, 8'h00, 1'b1}};

  // Free-running clock of 50 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ufc_top i_dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CTS_PIN(cts), .RTS_PIN(rts),
    .TX_HALT(tx_halt), .RX_CHAR(rx_char), .TX_FREE(tx_free),
    .RX_FILL(rx_fill), .BAUD_DIVISOR(baud), .SWFLOW_MODE(swflow),
    .SLEEP_EN(sleep_en), .RX_TRIG_LEVEL(rx_lvl), .TX_TRIG_LEVEL(tx_lvl),
    .RX_TRIG_HIT(rx_hit), .TX_TRIG_HIT(tx_hit), .IRQ(irq));

  ufc_remote_model i_remote (.clk(sys_clk), .rst_b(rst_b), .rts(rts),
    .send(send), .drain(drain), .fill(rx_fill));

  // One bus transfer; read data and error are taken at the ready edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts a comparison and reports a mismatch at once.
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits n edges, then moves to the falling edge where outputs settle.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      stop_test();
    end
  end

  // Main sequence: table of register cases, then the hand-written ones.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].w);
      xfer(1'b0, rows[i].a, 8'h00);
      cmp("row read", {24'h0, rows[i].r}, rd);
      cmp("row error", {31'h0, rows[i].e}, {31'h0, er});
    end
    tick(1);
    cmp("flow mode", 32'hf, {28'h0, swflow});
    cmp("divisor", 32'h1234, {16'h0, baud});
    xfer(1'b1, ufc_pkg::ADDR_INT_ENABLE, 8'h10);
    xfer(1'b1, ufc_pkg::ADDR_DIV_LOW, 8'h99);
    tick(1);
    cmp("sleep", 32'h1, {31'h0, sleep_en});
    cmp("divisor in sleep", 32'h1234, {16'h0, baud});
    xfer(1'b1, ufc_pkg::ADDR_INT_ENABLE, 8'h00);
    cmp("rx level", 32'h0c, {25'h0, rx_lvl});
    cmp("tx level", 32'h08, {25'h0, tx_lvl});
    xfer(1'b1, ufc_pkg::ADDR_TRIG_LEVELS, 8'h30);
    tick(1);
    cmp("tx fallback", 32'(ufc_pkg::FCT_TX_LVL[3]), {25'h0, tx_lvl});
    cmp("rx kept", 32'h0c, {25'h0, rx_lvl});
    xfer(1'b1, ufc_pkg::ADDR_EVT_STATUS, 8'h1f);
    xfer(1'b1, ufc_pkg::ADDR_EVT_MASK, 8'h10);
    @(posedge sys_clk);
    tx_free <= 7'h30;
    tick(3);
    cmp("tx hit low", 32'h0, {31'h0, tx_hit});
    @(posedge sys_clk);
    tx_free <= 7'h40;
    tick(3);
    cmp("irq raised", 32'h1, {31'h0, irq});
    xfer(1'b1, ufc_pkg::ADDR_EVT_MASK, 8'h00);
    tick(1);
    cmp("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, ufc_pkg::ADDR_EVT_MASK, 8'h10);
    xfer(1'b1, ufc_pkg::ADDR_EVT_STATUS, 8'h10);
    tick(1);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    xfer(1'b1, ufc_pkg::ADDR_STOP_CHAR2, 8'h13);
    xfer(1'b1, ufc_pkg::ADDR_ENH_FEATURE, 8'h3f);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      rx_char <= {1'b1, 8'h11 + 8'(2 * i)};
      @(posedge sys_clk);
      rx_char <= '0;
      xfer(1'b0, ufc_pkg::ADDR_INT_IDENT, 8'h00);
      cmp("special flag", i, {31'h0, rd[ufc_pkg::IDN_SPECIAL]});
    end
    @(posedge sys_clk);
    cts <= 1'b1;
    tick(4);
    cmp("halt disabled", 32'h0, {31'h0, tx_halt});
    xfer(1'b1, ufc_pkg::ADDR_ENH_FEATURE, 8'hbf);
    tick(4);
    cmp("halt on", 32'h1, {31'h0, tx_halt});
    @(posedge sys_clk);
    cts <= 1'b0;
    tick(4);
    cmp("halt off", 32'h0, {31'h0, tx_halt});
    xfer(1'b1, ufc_pkg::ADDR_ENH_FEATURE, 8'hff);
    @(posedge sys_clk);
    send <= 1'b1;
    do tick(0); while (rts !== 1'b1);
    tick(3);
    cmp("rts halt", 32'h1, {31'h0, rts});
    cmp("halt fill", 32'h1, {31'h0, rx_fill inside {[16:18]}});
    xfer(1'b0, ufc_pkg::ADDR_RX_FILL, 8'h00);
    cmp("fill read", {25'h0, rx_fill}, rd);
    @(posedge sys_clk);
    send  <= 1'b0;
    drain <= 1'b1;
    for (int n = 0; n < 200 && rts !== 1'b0; n++) @(posedge sys_clk);
    drain <= 1'b0;
    tick(1);
    cmp("resume fill", 32'h1, {31'h0, rx_fill inside {[5:8]}});
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    xfer(1'b0, ufc_pkg::ADDR_ENH_FEATURE, 8'h00);
    cmp("feature reset", 32'h0, rd);
    cmp("rts reset", 32'h1, {31'h0, rts});
    cmp("tx reset", 32'(ufc_pkg::FCT_TX_LVL[0]), {25'h0, tx_lvl});
    stop_test();
  end
endmodule
